// ===== logic/pcss_scheduler.sv
// pulse channel sampling scheduler top
`default_nettype none

module pcss_scheduler #(
  parameter int TICK_CYCLES_P   = pcss_pkg::TICK_CYCLES,
  parameter int MODULE_CYCLES_P = pcss_pkg::MODULE_CYCLES
) (
  input  wire logic                                   sys_clk,
  input  wire logic                                   reset,
  input  wire pcss_pkg::pcss_table_cfg_type [2:0]     table_cfg,
  input  wire logic [2:0]                             table_busy,
  input  wire logic [3:0][pcss_pkg::COUNT_W-1:0]      count_in,
  output logic [3:0]                                  cnt_clear,
  output pcss_pkg::pcss_sample_type                   sample,
  output logic [2:0]                                  table_go,
  output logic                                        overrun_flag
);
  import pcss_pkg::*;

  // ************************************************************
  // state
  // ************************************************************
  logic [23:0]             tick_cnt;
  logic [23:0]             next_tick_cnt;
  logic                    tick;
  logic                    next_tick;
  logic [2:0]              due;
  logic [2:0]              ovr;
  logic [2:0]              ok;
  pcss_state_type          state;
  pcss_state_type          next_state;
  logic [1:0]              tbl;
  logic [1:0]              next_tbl;
  logic [1:0]              mod;
  logic [1:0]              next_mod;
  logic [2:0]              due_set;
  logic [2:0]              next_due_set;
  logic [2:0]              pend;
  logic [2:0]              next_pend;
  logic [16:0]             wait_cnt;
  logic [16:0]             next_wait_cnt;
  logic [3:0][COUNT_W-1:0] prev;
  logic [3:0][COUNT_W-1:0] next_prev;
  logic [3:0]              next_clear;
  pcss_sample_type         next_sample;
  logic [2:0]              next_go;
  logic                    next_overrun;
  logic                    advance;
  logic                    repl;

  // ************************************************************
  // interval counters, one per table
  // ************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < NUM_TABLES; gi++) begin : g_ivl
      pcss_interval u_ivl (
        .sys_clk  (sys_clk),
        .reset    (reset),
        .tick     (tick),
        .interval (table_cfg[gi].interval),
        .due      (due[gi])
      );
    end
  endgenerate

  // a due table still busy from its last run is an overrun
  assign ovr = due & table_busy;
  assign ok  = due & ~table_busy;

  // ************************************************************
  // tick divider and sampling sequencer
  // ************************************************************
  always_comb begin
    next_tick     = 1'b0;
    next_tick_cnt = tick_cnt - 24'h00_0001;
    if (tick_cnt == 24'h00_0000) begin
      next_tick     = 1'b1;
      next_tick_cnt = 24'(TICK_CYCLES_P - 1);
    end
    next_state    = state;
    next_tbl      = tbl;
    next_mod      = mod;
    next_due_set  = due_set;
    next_pend     = pend;
    next_wait_cnt = wait_cnt;
    next_prev     = prev;
    next_clear    = 4'h0;
    next_sample   = '0;
    next_go       = 3'h0;
    advance       = 1'b0;
    repl          = table_cfg[tbl].discard_en && pend[tbl];
    case (state)
      ST_IDLE: begin
        if (due_set != 3'h0) begin
          next_state = ST_SCAN;
          next_tbl   = 2'h0;
          next_mod   = 2'h0;
        end
      end
      ST_SCAN: begin
        // sample referenced modules of a due table
        if (due_set[tbl] && table_cfg[tbl].module_mask[mod]) begin
          next_clear[mod]       = 1'b1;
          next_sample.valid     = 1'b1;
          next_sample.table_id  = tbl;
          next_sample.module_id = mod;
          // overrun sample replaced by previous good count
          next_sample.replaced  = repl;
          next_sample.count     = repl ? prev[mod] : count_in[mod];
          if (!repl) begin
            next_prev[mod] = count_in[mod];
          end
          // hold off the next module for one module time
          next_wait_cnt = 17'(MODULE_CYCLES_P - 1);
          next_state    = ST_WAIT;
        end else begin
          advance = 1'b1;
        end
      end
      ST_WAIT: begin
        if (wait_cnt == 17'h0_0000) begin
          advance = 1'b1;
        end else begin
          next_wait_cnt = wait_cnt - 17'h0_0001;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    if (advance) begin
      next_state = ST_SCAN;
      if (mod == 2'h3) begin
        next_mod = 2'h0;
        if (due_set[tbl]) begin
          // table may run once all its modules are read
          next_go[tbl]   = 1'b1;
          next_pend[tbl] = 1'b0;
        end
        if (tbl == 2'h2) begin
          next_state   = ST_IDLE;
          next_due_set = 3'h0;
        end else begin
          next_tbl = tbl + 2'h1;
        end
      end else begin
        next_mod = mod + 2'h1;
      end
    end
    // overrun tables are left out of this tick
    next_due_set = next_due_set | ok;
    // set after clear, so a fresh overrun is never lost
    next_pend    = next_pend | ovr;
    next_overrun = overrun_flag;
    if (ok != 3'h0) begin
      next_overrun = 1'b0;
    end
    // overrun raises the indicator, wins over the clear
    if (ovr != 3'h0) begin
      next_overrun = 1'b1;
    end
  end

  // register everything, outputs straight from flops
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      tick_cnt     <= 24'h00_0000;
      tick         <= 1'b0;
      state        <= ST_IDLE;
      tbl          <= 2'h0;
      mod          <= 2'h0;
      due_set      <= 3'h0;
      pend         <= 3'h0;
      wait_cnt     <= 17'h0_0000;
      prev         <= '0;
      cnt_clear    <= 4'h0;
      sample       <= '0;
      table_go     <= 3'h0;
      overrun_flag <= 1'b0;
    end else begin
      tick_cnt     <= next_tick_cnt;
      tick         <= next_tick;
      state        <= next_state;
      tbl          <= next_tbl;
      mod          <= next_mod;
      due_set      <= next_due_set;
      pend         <= next_pend;
      wait_cnt     <= next_wait_cnt;
      prev         <= next_prev;
      cnt_clear    <= next_clear;
      sample       <= next_sample;
      table_go     <= next_go;
      overrun_flag <= next_overrun;
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  logic [23:0] since_tick;
  logic        seen_tick;
  logic [16:0] since_sample;
  logic        have_last;
  logic [1:0]  last_tbl;
  logic [1:0]  last_mod;
  logic [3:0][COUNT_W-1:0] count_d;
  logic [3:0][COUNT_W-1:0] kept_cnt;

  // helper history, read only by the checks; kept_cnt is the checks' own copy of the last good counts
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      since_tick   <= 24'h00_0000;
      seen_tick    <= 1'b0;
      since_sample <= 17'h0_0000;
      have_last    <= 1'b0;
      last_tbl     <= 2'h0;
      last_mod     <= 2'h0;
      count_d      <= '0;
      kept_cnt     <= '0;
    end else begin
      count_d      <= count_in;
      since_tick   <= tick ? 24'h00_0000 : since_tick + 24'h00_0001;
      seen_tick    <= seen_tick | tick;
      since_sample <= sample.valid ? 17'h0_0000 : since_sample + 17'h0_0001;
      if (sample.valid) begin
        have_last <= 1'b1;
        last_tbl  <= sample.table_id;
        last_mod  <= sample.module_id;
        if (!sample.replaced) begin
          kept_cnt[sample.module_id] <= sample.count;
        end
      end else if (state == ST_IDLE) begin
        have_last <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  AST_CLEAR_PAIRS_SAMPLE: assert property (cnt_clear != 4'h0 |-> sample.valid && cnt_clear == 4'h1 << sample.module_id)
    else $error("counter clear not paired with its sample");
  AST_TICK_PERIOD: assert property (tick && seen_tick |-> since_tick == 24'(TICK_CYCLES_P - 1))
    else $error("tick spacing wrong");
  AST_ONLY_REFERENCED: assert property (sample.valid |-> table_cfg[sample.table_id].module_mask[sample.module_id])
    else $error("sampled a module the table does not reference");
  AST_OVERRUN_SKIPS: assert property (ovr != 3'h0 |=> (due_set & $past(ovr)) == 3'h0)
    else $error("overrun table was scheduled for sampling");
  AST_OVERRUN_FLAG: assert property (ovr != 3'h0 |=> overrun_flag)
    else $error("overrun indicator not raised");
  AST_REPLACED_COUNT: assert property (sample.valid && sample.replaced |-> sample.count == kept_cnt[sample.module_id])
    else $error("replaced sample is not the last good count");
  AST_CAPTURE_LIVE: assert property (sample.valid && !sample.replaced |-> sample.count == count_d[sample.module_id])
    else $error("sample count is not the live counter value");
  AST_TABLE_ORDER: assert property (sample.valid && have_last |-> sample.table_id >= last_tbl)
    else $error("table priority order broken");
  AST_MODULE_ORDER: assert property (sample.valid && have_last && sample.table_id == last_tbl |-> sample.module_id > last_mod)
    else $error("module order broken");
  AST_MODULE_GAP: assert property (sample.valid && have_last |-> since_sample >= 17'(MODULE_CYCLES_P))
    else $error("modules sampled too close together");
  AST_OVERRUN_CLEAR: assert property (ok != 3'h0 && ovr == 3'h0 |=> !overrun_flag)
    else $error("overrun indicator not cleared");

  COV_REPLACED: cover property (sample.valid && sample.replaced);
  COV_OVERRUN: cover property ($rose(overrun_flag));
  COV_TWO_TABLES: cover property (sample.valid && have_last && sample.table_id != last_tbl);

endmodule

`default_nettype wire

// ===== shared/pcss_pkg.sv
// constants and types of the pulse channel sampling scheduler
// What this block does
// - on each table run, capture pulse counter values, then clear the counters.
// - check every 0.1 second tick whether each table is due.
// - for a due table, sample and clear referenced modules before it runs.
// - a table delayed past its tick skips sampling until its next interval.
// - a table overrun raises the overrun indicator.
// - if enabled, an overrun sample is replaced by the previous good count.
// - tables due together are sampled in table priority order.
// - within a table, modules are sampled from module 1 up to module 4.
// - successive modules at one tick are spaced by about 0.6 ms.
`default_nettype none

package pcss_pkg;

  // ************************************************************
  // sizes
  // ************************************************************
  localparam int NUM_TABLES  = 3;
  localparam int NUM_MODULES = 4;
  localparam int COUNT_W     = 16;
  localparam int IVL_W       = 8;

  // ************************************************************
  // timing
  // ************************************************************
  localparam real CLK_PERIOD_NS  = 10.0;
  localparam real TICK_PERIOD_S  = 0.1;
  localparam real MODULE_TIME_MS = 0.6;
  localparam int  TICK_CYCLES    = int'(TICK_PERIOD_S * 1.0e9 / CLK_PERIOD_NS);
  // least time, so rounded up
  localparam int  MODULE_CYCLES  = int'($ceil(MODULE_TIME_MS * 1.0e6 / CLK_PERIOD_NS));

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [IVL_W-1:0] IVL_RESET = 8'h01;  // first tick after reset is due

  // ************************************************************
  // types
  // ************************************************************
  typedef struct packed {
    logic [3:0] module_mask;  // bit m: table holds a pulse-count request for module m+1
    logic [7:0] interval;     // run interval in ticks, zero disables the table
    logic       discard_en;   // replace overrun samples with the previous count
  } pcss_table_cfg_type;

  typedef struct packed {
    logic        valid;
    logic        replaced;
    logic [1:0]  table_id;
    logic [1:0]  module_id;
    logic [15:0] count;
  } pcss_sample_type;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_SCAN = 2'h1,
    ST_WAIT = 2'h2
  } pcss_state_type;

endpackage

`default_nettype wire

// ===== logic/pcss_interval.sv
// per-table interval counter that flags a table due on a tick
`default_nettype none

module pcss_interval (
  input  wire logic                      sys_clk,
  input  wire logic                      reset,
  input  wire logic                      tick,
  input  wire logic [pcss_pkg::IVL_W-1:0] interval,
  output logic                           due
);
  import pcss_pkg::*;

  logic [IVL_W-1:0] cnt;
  logic [IVL_W-1:0] next_cnt;
  logic             next_due;

  // count ticks down, reload on expiry
  always_comb begin
    next_cnt = cnt;
    next_due = 1'b0;
    if (tick) begin
      if (cnt <= 8'h01) begin
        next_due = (interval != 8'h00);
        next_cnt = interval;
      end else begin
        next_cnt = cnt - 8'h01;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      cnt <= IVL_RESET;
      due <= 1'b0;
    end else begin
      cnt <= next_cnt;
      due <= next_due;
    end
  end

endmodule

`default_nettype wire

// ===== bench/pcss_pulse_model.sv
// pulse counter model standing for the four input/output modules
`default_nettype none

module pcss_pulse_model (
  input  wire logic                                sys_clk,
  input  wire logic                                reset,
  input  wire logic [3:0]                          cnt_clear,
  output logic      [3:0][pcss_pkg::COUNT_W-1:0]   count_in
);
  timeunit 1ns;
  timeprecision 1ps;
  import pcss_pkg::*;

  // ************************************************************
  // counters
  // ************************************************************
  // cleared when read
  // module m gets m+1 pulses a cycle, so a wrong module id shows in the count
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      count_in <= '0;
    end else begin
      for (int m = 0; m < 4; m++) begin
        if (cnt_clear[m]) begin
          count_in[m] <= '0;
        end else begin
          count_in[m] <= count_in[m] + 16'(m + 1);
        end
      end
    end
  end
endmodule

`default_nettype wire

// ===== bench/tb_top.sv
// self-checking bench for the pulse channel sampling scheduler
`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import pcss_pkg::*;

  // short counts keep the run small; all expectations use these
  localparam int T = 200;
  localparam int M = 10;

  logic                        sys_clk    = 1'b0;
  logic                        reset      = 1'b1;
  pcss_table_cfg_type [2:0]    table_cfg  = '0;
  logic [2:0]                  table_busy = '0;
  logic [3:0][COUNT_W-1:0]     count_in;
  logic [3:0][COUNT_W-1:0]     prev;
  logic [3:0]                  cnt_clear;
  pcss_sample_type             sample;
  logic [2:0]                  table_go;
  logic [2:0]                  go_seen    = '0;
  logic                        overrun_flag;
  int                          cyc        = 0;
  int                          fail_count = 0;
  int                          compares   = 0;
  pcss_sample_type             q_s[$];
  int                          q_t[$];
  logic [15:0]                 q_p[$];
  logic [3:0]                  q_c[$];

  always #5 sys_clk = ~sys_clk;

  pcss_scheduler #(
    .TICK_CYCLES_P   (T),
    .MODULE_CYCLES_P (M)
  ) dut_u (
    .sys_clk      (sys_clk),
    .reset        (reset),
    .table_cfg    (table_cfg),
    .table_busy   (table_busy),
    .count_in     (count_in),
    .cnt_clear    (cnt_clear),
    .sample       (sample),
    .table_go     (table_go),
    .overrun_flag (overrun_flag)
  );

  pcss_pulse_model pulse_u (
    .sys_clk   (sys_clk),
    .reset     (reset),
    .cnt_clear (cnt_clear),
    .count_in  (count_in)
  );

  // ************************************************************
  // monitor
  // ************************************************************
  // log each sample with its cycle and the count seen before the edge
  always @(posedge sys_clk) begin
    prev <= count_in;
    cyc <= cyc + 1;
    #1;
    go_seen = go_seen | table_go;
    if (sample.valid === 1'b1) begin
      q_s.push_back(sample);
      q_t.push_back(cyc);
      q_p.push_back(prev[sample.module_id]);
      q_c.push_back(cnt_clear);
    end
  end

  // ************************************************************
  // helpers
  // ************************************************************
  task automatic check(input logic ok, input string msg);
    compares++;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("Error at %0t: %s", $time, msg);
    end
  endtask

  task automatic conclude();
    $display("compares %0d, fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // config only changes under reset, so the scheduler never sees it move
  task automatic restart(input pcss_table_cfg_type [2:0] cfg);
    @(posedge sys_clk);
    reset <= 1'b1;
    table_cfg <= cfg;
    table_busy <= 3'h0;
    repeat (5) @(posedge sys_clk);
    q_s.delete();
    q_t.delete();
    q_p.delete();
    q_c.delete();
    go_seen = '0;
    reset <= 1'b0;
  endtask

  task automatic wait_q(input int n, input int bound);
    for (int i = 0; i < bound && q_s.size() < n; i++) @(posedge sys_clk);
    #2;
    if (q_s.size() < n) begin
      fail_count++;
      $display("Error at %0t: sample wait ran out", $time);
      conclude();
    end
  endtask

  // ************************************************************
  // scenarios
  // ************************************************************
  // three tables due together, then a tick where table 2 is not due
  task automatic scn_order();
    pcss_table_cfg_type [2:0] cfg;
    int exp_t[7] = '{0, 0, 1, 2, 0, 0, 2};
    int exp_m[7] = '{1, 3, 0, 2, 1, 3, 2};
    cfg[0] = '{4'ha, 8'h01, 1'b0};
    cfg[1] = '{4'h1, 8'h02, 1'b0};
    cfg[2] = '{4'h4, 8'h01, 1'b0};
    restart(cfg);
    wait_q(7, 3 * T);
    for (int i = 0; i < 7; i++) begin
      check(q_s[i].table_id === 2'(exp_t[i]) && q_s[i].module_id === 2'(exp_m[i]), "sample order");
      check(q_s[i].count === q_p[i] && q_s[i].replaced === 1'b0, "sample count");
      check(q_c[i] === 4'(1 << exp_m[i]), "clear pulse");
      if (i > 0) check(q_t[i] - q_t[i-1] >= M + 1, "module spacing");
    end
    check(q_t[4] - q_t[0] == T, "tick period");
    check(go_seen === 3'h7, "table go");
  endtask

  // tables 1 and 3 busy at their second tick, only table 1 discards; then on time again
  task automatic scn_overrun();
    pcss_table_cfg_type [2:0] cfg;
    int i;
    cfg = '0;
    cfg[0] = '{4'h2, 8'h01, 1'b1};
    cfg[2] = '{4'h8, 8'h01, 1'b0};
    restart(cfg);
    wait_q(2, 2 * T);
    @(posedge sys_clk);
    table_busy <= 3'h5;
    for (i = 0; i < 2 * T && overrun_flag !== 1'b1; i++) @(posedge sys_clk);
    #2;
    check(overrun_flag === 1'b1, "overrun flag");
    if (overrun_flag !== 1'b1) conclude();
    check(q_s.size() == 2, "no sample on overrun");
    @(posedge sys_clk);
    table_busy <= 3'h0;
    wait_q(4, 2 * T);
    check(q_s[2].replaced === 1'b1 && q_s[2].count === q_s[0].count, "replaced count");
    check(q_s[3].table_id === 2'h2 && q_s[3].replaced === 1'b0 && q_s[3].count === q_p[3], "live count");
    check(overrun_flag === 1'b0, "flag cleared");
    check(q_t[2] - q_t[0] == 2 * T, "skipped interval");
    wait_q(6, 2 * T);
    check(q_s[4].replaced === 1'b0 && q_s[4].count === q_p[4], "good count after");
    check(q_t[4] - q_t[2] == T, "back on tick");
  endtask

  initial begin
    scn_order();
    scn_overrun();
    conclude();
  end
endmodule

`default_nettype wire
